// ---- bench/cpu_core_model.sv ----
// CPU core model driving the flash control ports on the falling edge
`timescale 1ns/1ps
module cpu_core_model (
    // Clock
    input  wire logic              clk_in,
    // Register and data-space writes
    output logic                   ctl_wr_out,
    output logic [7:0]             ctl_data_out,
    output logic                   boot_wr_out,
    output logic                   boot_space_map_out,
    output logic                   ext_ram_select_out,
    output flash_ctl_pkg::xwrite_t xwr_out,
    // Code read address
    output logic [15:0]            code_addr_out
);
    // Quiet bus at time zero
    initial begin
        ctl_wr_out         = 1'b0;
        ctl_data_out       = 8'h00;
        boot_wr_out        = 1'b0;
        boot_space_map_out = 1'b0;
        ext_ram_select_out = 1'b0;
        xwr_out            = '0;
        code_addr_out      = 16'h0000;
    end
    // One-cycle control write; data inverted once released
    task automatic ctl_write(input logic [7:0] d);
        @(negedge clk_in);
        ctl_wr_out   = 1'b1;
        ctl_data_out = d;
        @(negedge clk_in);
        ctl_wr_out   = 1'b0;
        ctl_data_out = ~d;
    endtask
    // Keyed launch, key 5 then key A with the same control bits
    task automatic launch(input logic [1:0] sp, input logic [1:0] lo);
        ctl_write({4'h5, lo[1], sp, lo[0]});
        ctl_write({4'ha, lo[1], sp, lo[0]});
    endtask
    // One-cycle data-space write
    task automatic data_write(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_in);
        xwr_out = '{wr: 1'b1, addr: a, data: d};
        @(negedge clk_in);
        xwr_out = '{wr: 1'b0, addr: ~a, data: ~d};
    endtask
    // Boot map bit write
    task automatic boot_write(input logic bm);
        @(negedge clk_in);
        boot_wr_out        = 1'b1;
        boot_space_map_out = bm;
        @(negedge clk_in);
        boot_wr_out        = 1'b0;
    endtask
    // Level inputs
    task automatic set_levels(input logic ext, input logic [15:0] a);
        @(negedge clk_in);
        ext_ram_select_out = ext;
        code_addr_out      = a;
    endtask
endmodule // cpu_core_model

// ---- bench/tb.sv ----
// Self-checking bench for the program flash control block
`timescale 1ns/1ps
module tb;
    logic                   clk_in, rst_in, cwr, cbw, cbm, cext, busy, idle, fblk;
    logic                   bsel, ssel, xsel, xwe, ren, mwe, mer, lat;
    logic [7:0]             cdat, fcr, mdata, pg;
    logic [15:0]            caddr, a;
    logic [14:0]            maddr;
    logic [31:0]            r;
    logic [1:0]             seen;
    flash_ctl_pkg::xwrite_t xwr;
    flash_ctl_pkg::space_t  msp;
    logic [7:0]             exp_lat [0:127];
    logic [127:0]           ld;
    logic [15:0]            corner [0:5] = '{16'hf3ff, 16'hff7f, 16'h0, 16'hf400, 16'hff80, 16'h1};
    int                     error_cnt, compares, seed, ner, nwe, nwr;
    // Design and CPU model
    flash_program_control flash_program_control_i (.clk_in(clk_in), .rst_in(rst_in),
        .ctl_wr_in(cwr), .ctl_data_in(cdat), .boot_wr_in(cbw), .boot_space_map_in(cbm),
        .ext_ram_select_in(cext), .xwr_in(xwr), .code_addr_in(caddr),
        .flash_control_reg_out(fcr), .prog_in_progress_out(busy), .cpu_idle_out(idle),
        .fetch_block_out(fblk), .boot_sel_out(bsel), .sec_sel_out(ssel), .spare_loader_row_sel_out(xsel),
        .xram_we_out(xwe), .ram_en_out(ren), .mem_we_out(mwe), .mem_erase_out(mer),
        .mem_space_out(msp), .mem_addr_out(maddr), .mem_data_out(mdata));
    cpu_core_model cpu_core_model_i (.clk_in(clk_in), .ctl_wr_out(cwr), .ctl_data_out(cdat),
        .boot_wr_out(cbw), .boot_space_map_out(cbm), .ext_ram_select_out(cext),
        .xwr_out(xwr), .code_addr_out(caddr));
    // 20 MHz clock
    initial clk_in = 1'b0;
    always #25 clk_in = ~clk_in;
    // Expected code-space selects
    function automatic logic [2:0] exp_sel(logic bm, logic [1:0] sp, logic [15:0] ad);
        return {bm && ad >= 16'hf400, sp == 2'b01 && ad >= 16'hff80, sp == 2'b10 && ad == 16'h0};
    endfunction
    // Compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    // Counts and verdict
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Five-cycle reset
    task automatic do_reset;
        rst_in = 1'b1;
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
    endtask
    // Load the latch, launch one space, watch the passes
    task automatic run_space(input logic [1:0] sp);
        do_reset();
        ld = '0;
        check(8'({busy, idle, fblk}), 8'h0);
        cpu_core_model_i.ctl_write({4'h0, 1'b1, sp, 1'b0});
        r = $random(seed);
        nwr = 1 + r[3:0] % 6;
        for (int i = 0; i < nwr; i++) begin
            r = $random(seed);
            a = (sp == 2'b10) ? 16'h0 : (i == 0) ? 16'h7fff : {1'b0, r[14:0]};
            cpu_core_model_i.data_write(a, r[23:16]);
            exp_lat[a[6:0]] = (sp == 2'b10) ? (r[23:16] & 8'hf0) : r[23:16];
            ld[a[6:0]] = 1'b1;
            pg = a[14:7];
        end
        cpu_core_model_i.launch(sp, r[25:24]);
        ner = 0;
        nwe = 0;
        for (int k = 0; k < 300; k++) begin
            if (k == 2)
                check(8'({busy, idle, fblk}), (sp == 2'b11) ? 8'h0 : 8'h7);
            if (mer === 1'b1) begin
                ner++;
                check(8'(ld[maddr[6:0]]), 8'h1);
                check(maddr[14:7], pg);
            end
            if (mwe === 1'b1) begin
                nwe++;
                check(8'(ld[maddr[6:0]]), 8'h1);
                check(mdata, exp_lat[maddr[6:0]]);
                check(8'(msp), 8'(sp));
                check(maddr[14:7], pg);
            end
            @(negedge clk_in);
        end
        check(8'(ner), (sp == 2'b11) ? 8'h0 : 8'($countones(ld)));
        check(8'(nwe), (sp == 2'b11) ? 8'h0 : 8'($countones(ld)));
        cpu_core_model_i.ctl_write(8'h00);
        @(negedge clk_in);
        check(8'(busy), (sp == 2'b11) ? 8'h0 : 8'h1);
    endtask
    // Watchdog
    initial begin
        #(50 * 20000);
        error_cnt++;
        wrap_up();
    end
    // Main sequence
    initial begin
        seed = 32'he6d3;
        do_reset();
        check(fcr, 8'h00);
        cpu_core_model_i.ctl_write(8'h5f);
        @(negedge clk_in);
        check(fcr, 8'h5e);
        // Key A alone, then 5 broken by another write
        do_reset();
        cpu_core_model_i.ctl_write(8'ha0);
        cpu_core_model_i.ctl_write(8'h50);
        cpu_core_model_i.ctl_write(8'h30);
        cpu_core_model_i.ctl_write(8'ha0);
        repeat (3) @(negedge clk_in);
        check(8'({busy, idle}), 8'h0);
        // Code-space decode
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            a = (i < 6) ? corner[i] : r[15:0];
            cpu_core_model_i.boot_write((i % 3 == 0) && r[16]);
            cpu_core_model_i.ctl_write({5'h0, 2'(i % 3), 1'b0});
            cpu_core_model_i.set_levels(r[19], a);
            repeat (2) @(negedge clk_in);
            check(8'({bsel, xsel, ssel}), 8'(exp_sel((i % 3 == 0) && r[16], 2'(i % 3), a)));
        end
        // Data-space write routing
        for (int i = 0; i < 10; i++) begin
            r = $random(seed);
            a = (i == 0) ? 16'h7fff : (i == 1) ? 16'h8000 : r[15:0];
            cpu_core_model_i.ctl_write({4'h0, r[17] | (i < 2), 3'b000});
            cpu_core_model_i.set_levels(r[18], 16'h0);
            cpu_core_model_i.data_write(a, r[7:0]);
            seen = {xwe, ren};
            @(negedge clk_in);
            seen = seen | {xwe, ren};
            lat = (r[17] | (i < 2)) && (a <= 16'h7fff);
            check(8'(seen), 8'({!lat && r[18], !lat && !r[18]}));
        end
        for (int s = 0; s < 4; s++)
            run_space(2'(s));
        wrap_up();
    end
endmodule // tb

// ---- rtl/flash_ctl_defs.svh ----
// Constants for the program flash control block
`ifndef FLASH_CTL_DEFS_SVH
`define FLASH_CTL_DEFS_SVH
`define FC_BUSY_BIT        0
`define FC_MOD_LSB         1
`define FC_MAP_BIT         3
`define FC_KEY_LSB         4
`define FC_RESET           8'h00
`define FC_KEY_FIRST       4'h5
`define FC_KEY_SECOND      4'ha
`define FC_LATCH_TOP       16'h7fff
`define FC_BOOT_BASE       16'hf400
`define FC_SPARE_LOADER_ROW_BASE       16'hff80
`define FC_SEC_ADDR        16'h0000
`define FC_SEC_SW_MASK     8'hf0
`define FC_PROG_TIME_US    10000
`define FC_CLK_MHZ         20
`define FC_PROG_CYCLES     (`FC_PROG_TIME_US * `FC_CLK_MHZ)
`define FC_PAGE_BYTES      128
`endif

// ---- rtl/flash_ctl_pkg.sv ----
// Types for the program flash control block
package flash_ctl_pkg;
    typedef enum logic [1:0] {
        SP_USER = 2'b00,
        SP_SPARE_LOADER_ROW = 2'b01,
        SP_SEC  = 2'b10,
        SP_RSVD = 2'b11
    } space_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_ERASE = 2'b10,
        ST_PROG  = 2'b11
    } state_t;
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  data;
    } xwrite_t;
    typedef struct packed {
        state_t      st;
        logic [3:0]  key;
        logic        map;
        space_t      space;
        logic        boot_map;
        logic [7:0]  page;
        logic [127:0] loaded;
        logic [127:0][7:0] latch;
        logic [17:0] cnt;
        logic [6:0]  idx;
        logic        busy;
        logic        idle;
        logic        mem_we;
        logic        mem_erase;
        space_t      mem_space;
        logic [14:0] mem_addr;
        logic [7:0]  mem_data;
        logic        xram_we;
        logic        ram_en;
    } ctl_state_t;
endpackage

// ---- rtl/flash_program_control.sv ----
// Program flash control: latch buffer, mapping and keyed programming sequencer
// How it works
// - Main array is up to 32 Kbytes in 128-byte pages of code
// - Boot space map bit places 3 Kbyte boot array at F400h-FFFFh
// - A separate 128-byte spare loader row lives in the main flash
// - Security byte: software writes upper nibble only, lower nibble read-only
// - One-page column latch buffer feeds array, spare row and security byte
// - After reset the user array is reached by code reads only
// - With latch map set and no programming running, data writes 0000h-7FFFh land in the latch
// - Address bits 6:0 pick the byte, bits 14:7 pick the page
// - Latch map bit wins over the external RAM select bit
// - Space select: 00 user, 01 spare row FF80h, 10 security 0000h, 11 reserved
// - Programming starts only on key 5 then key A
// - After the key, program latch into selected space; 11 or 5 alone do nothing
// - Once launched, flash is busy and supplies no instruction fetches
// - CPU held idle during programming, released automatically at the end
// - Only the main flash is programmable in system, never the boot array
// - Busy flag is set and cleared by hardware only
// - Loaded locations are erased first, then programmed
// - Target page is taken from the last latch write
`timescale 1ns/1ps
`include "flash_ctl_defs.svh"
module flash_program_control (
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    // Control register write port
    input  wire logic                  ctl_wr_in,
    input  wire logic [7:0]            ctl_data_in,
    input  wire logic                  boot_wr_in,
    input  wire logic                  boot_space_map_in,
    input  wire logic                  ext_ram_select_in,
    // Data space write
    input  wire flash_ctl_pkg::xwrite_t xwr_in,
    // Code space read address
    input  wire logic [15:0]           code_addr_in,
    // Status and routing
    output logic [7:0]                 flash_control_reg_out,
    output logic                       prog_in_progress_out,
    output logic                       cpu_idle_out,
    output logic                       fetch_block_out,
    output logic                       boot_sel_out,
    output logic                       sec_sel_out,
    output logic                       spare_loader_row_sel_out,
    output logic                       xram_we_out,
    output logic                       ram_en_out,
    // Flash array write port
    output logic                       mem_we_out,
    output logic                       mem_erase_out,
    output flash_ctl_pkg::space_t      mem_space_out,
    output logic [14:0]                mem_addr_out,
    output logic [7:0]                 mem_data_out
);
    flash_ctl_pkg::ctl_state_t s_r, s_nxt;
    logic boot_sel_r, sec_sel_r, spare_loader_row_sel_r;
    logic [17:0] prog_cnt;
    assign prog_cnt = 18'(`FC_PROG_CYCLES);

    // Next state of the block, apart from the code-space select flops
    always_comb begin
        s_nxt = s_r;
        s_nxt.mem_we = 1'b0;
        s_nxt.mem_erase = 1'b0;
        s_nxt.xram_we = 1'b0;
        s_nxt.ram_en = 1'b0;
        if (boot_wr_in) begin
            s_nxt.boot_map = boot_space_map_in;
        end
        // Latch loading while mapped, ahead of external RAM
        if (xwr_in.wr && s_r.map && xwr_in.addr <= `FC_LATCH_TOP && !s_r.busy) begin
            s_nxt.latch[xwr_in.addr[6:0]] = xwr_in.data;
            s_nxt.loaded[xwr_in.addr[6:0]] = 1'b1;
            s_nxt.page = xwr_in.addr[14:7];
        end else if (xwr_in.wr) begin
            s_nxt.xram_we = ext_ram_select_in;
            s_nxt.ram_en = !ext_ram_select_in;
        end
        // Control register writes; busy bit is never software writable
        if (ctl_wr_in && !s_r.busy) begin
            s_nxt.key = ctl_data_in[`FC_KEY_LSB +: 4];
            s_nxt.map = ctl_data_in[`FC_MAP_BIT];
            s_nxt.space = flash_ctl_pkg::space_t'(ctl_data_in[`FC_MOD_LSB +: 2]);
        end
        case (s_r.st)
            flash_ctl_pkg::ST_IDLE: begin
                if (ctl_wr_in && ctl_data_in[7:4] == `FC_KEY_FIRST) begin
                    s_nxt.st = flash_ctl_pkg::ST_ARMED;
                end
            end
            flash_ctl_pkg::ST_ARMED: begin
                if (ctl_wr_in) begin
                    if (ctl_data_in[7:4] == `FC_KEY_SECOND &&
                        ctl_data_in[2:1] != 2'b11) begin
                        s_nxt.st = flash_ctl_pkg::ST_ERASE;
                        s_nxt.busy = 1'b1;
                        s_nxt.idle = 1'b1;
                        s_nxt.idx = 7'h00;
                        s_nxt.cnt = 18'h00000;
                    end else if (ctl_data_in[7:4] != `FC_KEY_FIRST) begin
                        s_nxt.st = flash_ctl_pkg::ST_IDLE;
                    end
                end
            end
            flash_ctl_pkg::ST_ERASE, flash_ctl_pkg::ST_PROG: begin
                // Walk loaded latch bytes, erase pass then program pass
                // Wait phase parks on the last byte with cnt running; no pulses then
                if (s_r.loaded[s_r.idx] && s_r.cnt == 18'h00000) begin
                    s_nxt.mem_erase = (s_r.st == flash_ctl_pkg::ST_ERASE);
                    s_nxt.mem_we = (s_r.st == flash_ctl_pkg::ST_PROG);
                    s_nxt.mem_space = s_r.space;
                    s_nxt.mem_addr = {s_r.page, s_r.idx};
                    s_nxt.mem_data = (s_r.space == flash_ctl_pkg::SP_SEC) ?
                        (s_r.latch[s_r.idx] & `FC_SEC_SW_MASK) : s_r.latch[s_r.idx];
                end
                s_nxt.idx = s_r.idx + 7'h01;
                if (s_r.idx == 7'h7f) begin
                    s_nxt.st = (s_r.st == flash_ctl_pkg::ST_ERASE) ?
                        flash_ctl_pkg::ST_PROG : flash_ctl_pkg::ST_ERASE;
                    if (s_r.st == flash_ctl_pkg::ST_PROG) begin
                        s_nxt.st = flash_ctl_pkg::ST_PROG;
                        s_nxt.idx = 7'h7f;
                        s_nxt.cnt = s_r.cnt + 18'h00001;
                        if (s_r.cnt >= prog_cnt) begin
                            s_nxt.st = flash_ctl_pkg::ST_IDLE;
                            s_nxt.busy = 1'b0;
                            s_nxt.idle = 1'b0;
                            s_nxt.loaded = '0;
                            s_nxt.key = 4'h0;
                        end
                    end
                end
            end
            default: s_nxt.st = flash_ctl_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_r <= '0;
            boot_sel_r <= 1'b0;
            sec_sel_r <= 1'b0;
            spare_loader_row_sel_r <= 1'b0;
        end else begin
            s_r <= s_nxt;
            boot_sel_r <= s_nxt.boot_map && code_addr_in >= `FC_BOOT_BASE;
            spare_loader_row_sel_r <= s_nxt.space == flash_ctl_pkg::SP_SPARE_LOADER_ROW &&
                          code_addr_in >= `FC_SPARE_LOADER_ROW_BASE;
            sec_sel_r <= s_nxt.space == flash_ctl_pkg::SP_SEC &&
                         code_addr_in == `FC_SEC_ADDR;
        end
    end

    // Outputs straight from flops
    assign flash_control_reg_out = {s_r.key, s_r.map, s_r.space, s_r.busy};
    assign prog_in_progress_out = s_r.busy;
    assign fetch_block_out = s_r.busy;
    assign cpu_idle_out = s_r.idle;
    assign boot_sel_out = boot_sel_r;
    assign sec_sel_out = sec_sel_r;
    assign spare_loader_row_sel_out = spare_loader_row_sel_r;
    assign xram_we_out = s_r.xram_we;
    assign ram_en_out = s_r.ram_en;
    assign mem_we_out = s_r.mem_we;
    assign mem_erase_out = s_r.mem_erase;
    assign mem_space_out = s_r.mem_space;
    assign mem_addr_out = s_r.mem_addr;
    assign mem_data_out = s_r.mem_data;

    // Checks
    property p_busy_idle;
        @(posedge clk_in) disable iff (rst_in) prog_in_progress_out == cpu_idle_out;
    endproperty
    a_busy_idle: assert property (p_busy_idle) else $error("idle not tied to busy");
    property p_launch;
        @(posedge clk_in) disable iff (rst_in)
        (s_r.st == flash_ctl_pkg::ST_ARMED && ctl_wr_in && ctl_data_in[7:4] == 4'ha
         && ctl_data_in[2:1] != 2'b11) |=> prog_in_progress_out;
    endproperty
    a_launch: assert property (p_launch) else $error("key did not launch");
    property p_no_lone;
        @(posedge clk_in) disable iff (rst_in)
        (s_r.st == flash_ctl_pkg::ST_IDLE && !s_r.busy) |=> !prog_in_progress_out;
    endproperty
    a_no_lone: assert property (p_no_lone) else $error("launch without key 5");
    property p_rsvd;
        @(posedge clk_in) disable iff (rst_in)
        (ctl_wr_in && ctl_data_in[2:1] == 2'b11 && !s_r.busy) |=> !prog_in_progress_out;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved space launched");
    property p_sw_no_clear;
        @(posedge clk_in) disable iff (rst_in)
        (s_r.busy && s_r.st == flash_ctl_pkg::ST_ERASE) |=> prog_in_progress_out;
    endproperty
    a_sw_no_clear: assert property (p_sw_no_clear) else $error("busy dropped early");
    property p_latch;
        @(posedge clk_in) disable iff (rst_in)
        (xwr_in.wr && s_r.map && !xwr_in.addr[15] && !s_r.busy) |=>
        (s_r.page == $past(xwr_in.addr[14:7]) && !xram_we_out);
    endproperty
    a_latch: assert property (p_latch) else $error("latch write misrouted");
    property p_sec_mask;
        @(posedge clk_in) disable iff (rst_in)
        (mem_we_out && mem_space_out == flash_ctl_pkg::SP_SEC) |-> mem_data_out[3:0] == 4'h0;
    endproperty
    a_sec_mask: assert property (p_sec_mask) else $error("security low nibble written");
    property p_order;
        @(posedge clk_in) disable iff (rst_in)
        mem_we_out |-> s_r.st == flash_ctl_pkg::ST_PROG;
    endproperty
    a_order: assert property (p_order) else $error("program before erase pass");
    // No repeated array writes while the program time runs out
    property p_wait_quiet;
        @(posedge clk_in) disable iff (rst_in)
        (s_r.st == flash_ctl_pkg::ST_PROG && s_r.cnt != 18'h00000) |=> !mem_we_out;
    endproperty
    a_wait_quiet: assert property (p_wait_quiet) else $error("write in wait phase");
    // Fetches blocked exactly while busy
    property p_fetch;
        @(posedge clk_in) disable iff (rst_in) fetch_block_out == prog_in_progress_out;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch block not tied to busy");
    // Erase pulses only inside a busy window
    property p_erase_busy;
        @(posedge clk_in) disable iff (rst_in) mem_erase_out |-> prog_in_progress_out;
    endproperty
    a_erase_busy: assert property (p_erase_busy) else $error("erase while not busy");
    // Busy drops once the program time has elapsed
    property p_done;
        @(posedge clk_in) disable iff (rst_in)
        (s_r.busy && s_r.cnt >= prog_cnt) |=> !prog_in_progress_out;
    endproperty
    a_done: assert property (p_done) else $error("busy held past program time");
endmodule // flash_program_control
